// *** src/fsp_pkg.sv ***
// Package for the flash protection host controller
package fsp_pkg;
  // ---------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  // ---------------------------------------------------------------
  // Command codes (REG_CMD bits 3:0)
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_SECURE_ENTER = 4'h4;
  localparam logic [3:0] OP_SECURE_EXIT = 4'h5;
  localparam logic [3:0] OP_GROUP_QUERY = 4'h6;
  localparam logic [3:0] OP_RESET_CMD = 4'h7;
  // ---------------------------------------------------------------
  // Flash bus constants
  // ---------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam logic [21:0] UNLOCK_A1 = 22'h000555;
  localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
  localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_D2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
  localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
  localparam logic [15:0] CMD_SEC_EXIT = 16'h0090;
  localparam logic [15:0] CMD_SEC_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [21:0] GRP_QUERY_LOW = 22'h000002;
  localparam int GRP_LSB = 17;
  localparam int GRP_W = 5;
  localparam int DATA_BIT_SEVEN = 7;
  // ---------------------------------------------------------------
  // Timing: strobe low time must beat the glitch filter
  // ---------------------------------------------------------------
  localparam int CLK_PS = 4000;
  localparam int GLITCH_NS = 5;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SAMPLE_CYC = STROBE_CYC - 1;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
    logic rd;
  } fsp_cyc_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fsp_ctl_t;
endpackage

// *** src/fsp_bus_cycle.sv ***
// One flash bus cycle: strobe timing and data capture
`timescale 1ns/10ps
`default_nettype none
module fsp_bus_cycle
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Request
  input wire logic i_start,
  input wire fsp_cyc_t i_cyc,
  output logic o_done,
  output logic [15:0] o_rdata,
  // Flash pins
  output fsp_ctl_t o_ctl,
  output logic [21:0] o_addr,
  output logic [15:0] o_dq_o,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_i
);
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC + 1);
  localparam logic [7:0] SAMPLE_AT = 8'(SAMPLE_CYC);

  logic busy_q, busy_d;
  logic [7:0] cnt_q, cnt_d;
  fsp_cyc_t cyc_q, cyc_d;
  fsp_ctl_t ctl_q, ctl_d;
  logic done_q, done_d, oe_q, oe_d;
  logic [15:0] rd_q, rd_d;

  // Strobe held far longer than the device glitch filter
  always_comb
  begin
    busy_d = busy_q;
    cnt_d = cnt_q;
    cyc_d = cyc_q;
    ctl_d = ctl_q;
    done_d = 1'b0;
    rd_d = rd_q;
    if (!busy_q && i_start)
    begin
      busy_d = 1'b1;
      cnt_d = 8'h00;
      cyc_d = i_cyc;
    end
    else if (busy_q)
    begin
      cnt_d = cnt_q + 8'h01;
      // Only CE low + WE low + OE high writes; reads keep WE high
      ctl_d.ce_n = 1'b0;
      ctl_d.oe_n = ~cyc_q.rd;
      ctl_d.we_n = cyc_q.rd;
      if (cnt_q == SAMPLE_AT && cyc_q.rd)
        rd_d = i_dq_i;
      if (cnt_q == STROBE_LAST)
      begin
        ctl_d = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
    oe_d = busy_d & ~cyc_d.rd;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      cyc_q <= '0;
      // Idle strobes high so power-up never looks like a write
      ctl_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      done_q <= 1'b0;
      oe_q <= 1'b0;
      rd_q <= 16'h0000;
    end
    else
    begin
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      cyc_q <= cyc_d;
      ctl_q <= ctl_d;
      done_q <= done_d;
      oe_q <= oe_d;
      rd_q <= rd_d;
    end
  end

  assign o_done = done_q;
  assign o_rdata = rd_q;
  assign o_ctl = ctl_q;
  assign o_addr = cyc_q.addr;
  assign o_dq_o = cyc_q.data;
  assign o_dq_oe = oe_q;
endmodule
`default_nettype wire

// *** src/fsp_host.sv ***
// Host controller for a parallel NOR flash with sector protection
// ---------------------------------------------------------------
// Notes on behaviour
// - Protect/unprotect uses normal bus cycles with restart pin elevated.
// - Software, not the host, protects all groups before first unprotect cycle.
// - Secure lock uses three-cycle entry then sector protect algorithm.
// - Program only after unlock cycles in order.
// - Write only with chip select and write strobe low, output enable high.
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module fsp_host
  import fsp_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Flash pins
  output logic [21:0] o_flash_addr,
  output logic [15:0] o_dq_o,
  output logic o_dq_oe,
  input wire logic [15:0] i_dq_i,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_restart_n,
  output logic o_restart_elevate,
  output logic o_edge_lock_n,
  // Supply lockout flag from the board
  input wire logic i_supply_lockout
);
  // ---------------------------------------------------------------
  // Registers and sequencer state
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_ISSUE, S_WAIT} fsp_state_t;
  localparam logic [2:0] CNT_ONE = 3'h1;

  fsp_state_t st_q, st_d;
  logic [21:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic [15:0] rdat_q, rdat_d;
  logic [3:0] op_q, op_d;
  logic [2:0] step_q, step_d;
  logic [2:0] nstep_q, nstep_d;
  logic busy_q, busy_d;
  logic refused_q, refused_d;
  logic done_q, done_d;
  logic restart_n_q, restart_n_d;
  logic elev_q, elev_d;
  logic lock_n_q, lock_n_d;
  logic overlay_q, overlay_d;
  logic start_q, start_d;
  fsp_cyc_t cyc_q, cyc_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic aw_seen_q, aw_seen_d, w_seen_q, w_seen_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [2:0] lko_sync_q;

  // Lower-level bus cycle
  logic cyc_done;
  logic [15:0] cyc_rdata;
  fsp_ctl_t pin_ctl;
  logic [21:0] pin_addr;
  logic [15:0] pin_dq;
  logic pin_oe;

  fsp_bus_cycle u_cyc (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(start_q),
    .i_cyc(cyc_q),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_ctl(pin_ctl),
    .o_addr(pin_addr),
    .o_dq_o(pin_dq),
    .o_dq_oe(pin_oe),
    .i_dq_i(i_dq_i)
  );

  // Lockout flag from a pin: three stages, change taken when last two agree
  logic lko_q;
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      lko_sync_q <= 3'b000;
      lko_q <= 1'b0;
    end
    else
    begin
      lko_sync_q <= {lko_sync_q[1:0], i_supply_lockout};
      if (lko_sync_q[1] == lko_sync_q[2])
        lko_q <= lko_sync_q[2];
    end
  end

  // ---------------------------------------------------------------
  // Command step table
  // ---------------------------------------------------------------
  function automatic fsp_cyc_t step_cyc(input logic [3:0] op, input logic [2:0] s,
                                         input logic [21:0] a, input logic [15:0] d);
    fsp_cyc_t c;
    c = '{addr: UNLOCK_A1, data: UNLOCK_D1, rd: 1'b0};
    // Program, secure and group query commands open with the two unlock cycles in order
    if (s == 3'h1)
      c = '{addr: UNLOCK_A2, data: UNLOCK_D2, rd: 1'b0};
    else if (s == 3'h2)
    begin
      case (op)
        OP_PROGRAM: c.data = CMD_PROGRAM;
        OP_SECURE_ENTER: c.data = CMD_SEC_ENTER;
        OP_SECURE_EXIT: c.data = CMD_SEC_EXIT;
        OP_GROUP_QUERY: c.data = CMD_AUTOSEL;
        default: c.data = CMD_RESET;
      endcase
    end
    else if (s == 3'h3)
    begin
      case (op)
        OP_SECURE_EXIT: c = '{addr: a, data: CMD_SEC_EXIT2, rd: 1'b0};
        // Group code in the top bits, query offset in the low bits
        OP_GROUP_QUERY: c = '{addr: {a[21:17], 17'h00000} | GRP_QUERY_LOW, data: d,
                              rd: 1'b1};
        default: c = '{addr: a, data: d, rd: 1'b0};
      endcase
    end
    else if (s == 3'h4)
      c = '{addr: a, data: CMD_RESET, rd: 1'b0};
    return c;
  endfunction

  function automatic logic [2:0] last_step(input logic [3:0] op);
    case (op)
      OP_WRITE: last_step = 3'h0;
      OP_READ: last_step = 3'h0;
      OP_SECURE_ENTER: last_step = 3'h2;
      OP_GROUP_QUERY: last_step = 3'h4;
      OP_RESET_CMD: last_step = 3'h0;
      default: last_step = 3'h3;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // AXI slave and sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    op_d = op_q;
    step_d = step_q;
    nstep_d = nstep_q;
    busy_d = busy_q;
    refused_d = refused_q;
    done_d = done_q;
    restart_n_d = restart_n_q;
    elev_d = elev_q;
    lock_n_d = lock_n_q;
    overlay_d = overlay_q;
    start_d = 1'b0;
    cyc_d = cyc_q;
    awready_d = 1'b0;
    wready_d = 1'b0;
    bvalid_d = bvalid_q && !i_bready;
    arready_d = 1'b0;
    rvalid_d = rvalid_q && !i_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    aw_seen_d = aw_seen_q;
    w_seen_d = w_seen_q;
    awa_d = awa_q;
    wd_d = wd_q;

    if (i_awvalid && !aw_seen_q && !awready_q)
    begin
      awready_d = 1'b1;
      aw_seen_d = 1'b1;
      awa_d = i_awaddr;
    end
    if (i_wvalid && !w_seen_q && !wready_q)
    begin
      wready_d = 1'b1;
      w_seen_d = 1'b1;
      wd_d = i_wdata;
    end
    if (aw_seen_q && w_seen_q && !bvalid_q)
    begin
      aw_seen_d = 1'b0;
      w_seen_d = 1'b0;
      bvalid_d = 1'b1;
      if (i_wstrb[0])
      begin
        case (awa_q)
          REG_CMD:
          begin
            if (wd_q[31])
              done_d = 1'b0;
            // While lockout stands the device ignores writes; do not start
            if (!busy_q && wd_q[3:0] != 4'h0)
            begin
              if (lko_q)
                refused_d = 1'b1;
              else
              begin
                op_d = wd_q[3:0];
                step_d = 3'h0;
                nstep_d = last_step(wd_q[3:0]);
                busy_d = 1'b1;
                refused_d = 1'b0;
                st_d = S_ISSUE;
              end
            end
          end
          REG_ADDR: addr_d = wd_q[21:0];
          REG_WDATA: wdat_d = wd_q[15:0];
          REG_PINS:
          begin
            // Elevated level stands in for temporary unprotect and
            // the protect/unprotect algorithm run by software
            restart_n_d = wd_q[0];
            elev_d = wd_q[1];
            lock_n_d = wd_q[2];
          end
          default: ;
        endcase
      end
    end

    if (i_arvalid && !rvalid_q && !arready_q)
    begin
      arready_d = 1'b1;
      rvalid_d = 1'b1;
      rresp_d = 2'b00;
      case (i_araddr)
        REG_CMD: rdata_d = {28'h0000000, op_q};
        REG_ADDR: rdata_d = {10'h000, addr_q};
        REG_WDATA: rdata_d = {16'h0000, wdat_q};
        // Indicator bit (bit 7 of the read data) lands here for software; the query answer 01h/00h sits in REG_RDATA
        REG_STATUS: rdata_d = {24'h000000, rdat_q[DATA_BIT_SEVEN], 2'b00, lko_q,
                               overlay_q, refused_q, done_q, busy_q};
        REG_RDATA: rdata_d = {16'h0000, rdat_q};
        REG_PINS: rdata_d = {29'h00000000, lock_n_q, elev_q, restart_n_q};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = 2'b10;
        end
      endcase
    end

    case (st_q)
      S_IDLE: ;
      S_ISSUE:
      begin
        if (op_q == OP_READ)
          cyc_d = '{addr: addr_q, data: wdat_q, rd: 1'b1};
        else if (op_q == OP_WRITE)
          cyc_d = '{addr: addr_q, data: wdat_q, rd: 1'b0};
        else if (op_q == OP_RESET_CMD)
          cyc_d = '{addr: addr_q, data: CMD_RESET, rd: 1'b0};
        else
          cyc_d = step_cyc(op_q, step_q, addr_q, wdat_q);
        start_d = 1'b1;
        st_d = S_WAIT;
      end
      S_WAIT:
      begin
        if (cyc_done)
        begin
          if (cyc_q.rd)
            rdat_d = cyc_rdata;
          if (step_q == nstep_q)
          begin
            busy_d = 1'b0;
            done_d = 1'b1;
            st_d = S_IDLE;
            if (op_q == OP_SECURE_ENTER)
              overlay_d = 1'b1;
            else if (op_q == OP_SECURE_EXIT)
              overlay_d = 1'b0;
          end
          else
          begin
            step_d = step_q + CNT_ONE;
            st_d = S_ISSUE;
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    // Hardware restart drops the overlay in the device too
    if (!restart_n_q)
      overlay_d = 1'b0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      st_q <= S_IDLE;
      addr_q <= 22'h000000;
      wdat_q <= 16'h0000;
      rdat_q <= 16'h0000;
      op_q <= 4'h0;
      step_q <= 3'h0;
      nstep_q <= 3'h0;
      busy_q <= 1'b0;
      refused_q <= 1'b0;
      done_q <= 1'b0;
      restart_n_q <= 1'b1;
      elev_q <= 1'b0;
      lock_n_q <= 1'b1;
      overlay_q <= 1'b0;
      start_q <= 1'b0;
      cyc_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'b00;
      aw_seen_q <= 1'b0;
      w_seen_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
    end
    else
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      op_q <= op_d;
      step_q <= step_d;
      nstep_q <= nstep_d;
      busy_q <= busy_d;
      refused_q <= refused_d;
      done_q <= done_d;
      restart_n_q <= restart_n_d;
      elev_q <= elev_d;
      lock_n_q <= lock_n_d;
      overlay_q <= overlay_d;
      start_q <= start_d;
      cyc_q <= cyc_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      aw_seen_q <= aw_seen_d;
      w_seen_q <= w_seen_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bresp = 2'b00;
  assign o_bvalid = bvalid_q;
  assign o_arready = arready_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_rvalid = rvalid_q;
  assign o_flash_addr = pin_addr;
  assign o_dq_o = pin_dq;
  assign o_dq_oe = pin_oe;
  assign o_ce_n = pin_ctl.ce_n;
  assign o_oe_n = pin_ctl.oe_n;
  assign o_we_n = pin_ctl.we_n;
  assign o_restart_n = restart_n_q;
  assign o_restart_elevate = elev_q;
  assign o_edge_lock_n = lock_n_q;
endmodule
`default_nettype wire

// *** tb/fsp_host_props.sv ***
// Checker for the flash protection host controller
`timescale 1ns/10ps
`default_nettype none
module fsp_host_props
(
  // Clock, reset and board flag
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_supply_lockout,
  // Bus handshake
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic o_arready,
  input wire logic o_bvalid,
  input wire logic o_rvalid,
  input wire logic [1:0] o_rresp,
  // Flash pins
  input wire logic [21:0] o_flash_addr,
  input wire logic o_dq_oe,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  rst_idle_a: assert property ($fell(i_sys_rst) |-> o_ce_n && o_oe_n && o_we_n && !o_dq_oe)
    else $error("strobes not idle after reset");
  wr_logic_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
    else $error("write strobe without chip select or with output enable");
  we_width_a: assert property ($fell(o_we_n) |-> !o_we_n [*2])
    else $error("write strobe shorter than filter");
  rd_float_a: assert property (!o_oe_n |-> !o_dq_oe)
    else $error("host drives data during read");
  addr_hold_a: assert property (!o_ce_n && !$past(o_ce_n) |-> $stable(o_flash_addr))
    else $error("address moved inside a cycle");
  cyc_gap_a: assert property ($rose(o_ce_n) |-> o_ce_n [*2])
    else $error("cycles too close");
  lockout_quiet_a: assert property (i_supply_lockout [*8] |-> o_ce_n)
    else $error("bus cycle during lockout");
  bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  rvalid_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("read response dropped");
  ar_answer_a: assert property (o_arready |-> o_rvalid)
    else $error("read accepted without data");
  wr_seen_c: cover property ($fell(o_we_n));
  rd_seen_c: cover property ($fell(o_oe_n));
  slverr_c: cover property (o_rvalid && o_rresp == 2'b10);
endmodule
bind fsp_host fsp_host_props i_props (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_supply_lockout(i_supply_lockout), .i_bready(i_bready), .i_rready(i_rready),
  .o_arready(o_arready), .o_bvalid(o_bvalid), .o_rvalid(o_rvalid), .o_rresp(o_rresp),
  .o_flash_addr(o_flash_addr), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
  .o_we_n(o_we_n));
`default_nettype wire

// *** tb/fsp_flash_model.sv ***
// Behavioural flash device with group, edge and secure protection
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_model
  import fsp_pkg::*;
#(
  parameter bit FACTORY = 1'b0
)
(
  // Bus pins
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  output logic [15:0] o_dq,
  // Control pins
  input wire logic i_restart_n,
  input wire logic i_elevate,
  input wire logic i_edge_lock_n,
  input wire logic i_lockout
);
  logic [15:0] mem [logic [21:0]];
  logic [15:0] sec [logic [6:0]];
  logic [31:0] prot = '0;
  logic sec_lk = FACTORY;
  logic sec_on = 1'b0;
  logic asel = 1'b0;
  logic ex_p = 1'b0;
  logic [15:0] last = 16'h0;
  int stg = 0;
  realtime t0 = 0;
  wire logic [21:0] a_d;
  wire logic [15:0] d_d;
  wire logic w_ok;
  // Late copies: a strobe edge must see the pins as they were just before it
  assign #0.1 a_d = i_addr;
  assign #0.1 d_d = i_dq;
  assign #0.1 w_ok = !i_ce_n && i_oe_n;
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    if (ex_p)
    begin
      ex_p = 1'b0;
      if (d == CMD_SEC_EXIT2) sec_on = 1'b0;
    end
    else if (d == CMD_RESET)
      stg = 0;
    else if (a[1] && d == 16'h0060 && (i_elevate || sec_on))
    begin
      if (a[6] && sec_on) sec_lk = 1'b1;
      else if (a[6]) prot[a[21:17]] = 1'b1;
      else if (!sec_on) prot = '0;
    end
    else if (stg == 3)
    begin
      stg = 0;
      if (sec_on && a[21:7] == 15'h0)
      begin
        if (!sec_lk) sec[a[6:0]] = d;
      end
      else if (!((prot[a[21:17]] && !i_elevate) || (!i_edge_lock_n && a[21:15] == 7'h0)))
        mem[a] = d;
    end
    else if (stg == 2)
    begin
      stg = (d == CMD_PROGRAM) ? 3 : 0;
      if (d == CMD_SEC_ENTER) sec_on = 1'b1;
      if (d == CMD_AUTOSEL) {ex_p, asel} = sec_on ? 2'b10 : 2'b01;
    end
    else
      stg = (stg == 0 && a == UNLOCK_A1 && d == UNLOCK_D1) ? 1 :
        (stg == 1 && a == UNLOCK_A2 && d == UNLOCK_D2) ? 2 : 0;
    if (d == CMD_RESET) asel = 1'b0;
  endtask
  always @(negedge i_we_n) t0 = $realtime;
  always @(posedge i_we_n)
    if (w_ok && !i_lockout && $realtime - t0 >= 5.0) wr(a_d, d_d);
  always @(negedge i_restart_n or posedge i_lockout)
  begin
    asel = 1'b0;
    stg = 0;
    if (!i_restart_n) sec_on = 1'b0;
  end
  always @(i_ce_n or i_oe_n or i_addr)
    if (!i_ce_n && !i_oe_n)
    begin
      if (asel && i_addr[7:0] == 8'h02) last = {15'h0, prot[i_addr[21:17]]};
      else if (asel && i_addr[7:0] == 8'h03) last = {8'h0, FACTORY, 7'h18};
      else if (sec_on && i_addr[21:7] == 15'h0)
        last = sec.exists(i_addr[6:0]) ? sec[i_addr[6:0]] : 16'hffff;
      else last = mem.exists(i_addr) ? mem[i_addr] : 16'hffff;
      o_dq = last;
    end
    else
      o_dq = ~last; // No pull, so a released bus must not hold
endmodule
`default_nettype wire

// *** tb/fsp_host_tb_top.sv ***
// Testbench for the flash protection host controller
`timescale 1ns/10ps
`default_nettype none
module fsp_host_tb_top;
  import fsp_pkg::*;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, lock;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, s;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, oe_n, we_n, rs_n, elev, edge_n;
  logic [1:0] bresp, rresp, r;
  logic [21:0] faddr;
  logic [15:0] dq_o, mdq;
  wire logic [15:0] dq_i;
  int fails = 0;
  int num_checks = 0;
  assign dq_i = dq_oe ? dq_o : mdq;
  fsp_host i_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_flash_addr(faddr), .o_dq_o(dq_o), .o_dq_oe(dq_oe), .i_dq_i(dq_i), .o_ce_n(ce_n),
    .o_oe_n(oe_n), .o_we_n(we_n), .o_restart_n(rs_n), .o_restart_elevate(elev),
    .o_edge_lock_n(edge_n), .i_supply_lockout(lock));
  fsp_flash_model i_mdl (.i_addr(faddr), .i_dq(dq_o), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .o_dq(mdq), .i_restart_n(rs_n), .i_elevate(elev), .i_edge_lock_n(edge_n),
    .i_lockout(lock));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic a_on, w_on;
    a_on = 1'b1;
    w_on = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) a_on = 1'b0;
      if (wready) w_on = 1'b0;
      awvalid <= a_on;
      wvalid <= w_on;
    end
    while (a_on || w_on);
    while (!bvalid) @(posedge clk);
    chk(bresp, 2'b00);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    s = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Polled: flash cycle counts differ by command
  task automatic op(input logic [3:0] o, input logic [21:0] a, input logic [15:0] d);
    wr(REG_ADDR, {10'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, 32'h8000_0000);
    wr(REG_CMD, {28'h0, o});
    do rd(REG_STATUS); while (s[0] || !(s[1] || s[2]));
  endtask
  task automatic get(input logic [3:0] o, input logic [21:0] a);
    op(o, a, 16'h0);
    rd(REG_RDATA);
  endtask
  task automatic pins(input logic [2:0] v);
    wr(REG_PINS, {29'h0, v});
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk({ce_n, oe_n, we_n, dq_oe, rs_n, elev, edge_n}, 7'b1110101);
    rd(REG_PINS);
    chk(s[2:0], 3'b101);
    rd(8'h1c);
    chk(r, 2'b10);
    get(OP_GROUP_QUERY, 22'h060000);
    chk(s[15:0], 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_group();
    pins(3'b111);
    op(OP_WRITE, 22'h0a0042, 16'h0060);
    pins(3'b101);
    get(OP_GROUP_QUERY, 22'h0a0000);
    chk(s[15:0], 16'h0001);
    get(OP_GROUP_QUERY, 22'h080000);
    chk(s[15:0], 16'h0000);
    op(OP_PROGRAM, 22'h0bfff0, 16'h1111);
    get(OP_READ, 22'h0bfff0);
    chk(s[15:0], 16'hffff);
    pins(3'b111);
    op(OP_PROGRAM, 22'h0a0010, 16'h2222);
    get(OP_READ, 22'h0a0010);
    chk(s[15:0], 16'h2222);
    pins(3'b101);
    op(OP_PROGRAM, 22'h0a0020, 16'h3333);
    get(OP_READ, 22'h0a0020);
    chk(s[15:0], 16'hffff);
    pins(3'b111);
    for (int g = 0; g < 32; g++)
      op(OP_WRITE, {5'(g), 17'h00042}, 16'h0060);
    op(OP_WRITE, 22'h000002, 16'h0060);
    pins(3'b101);
    op(OP_PROGRAM, 22'h0a0020, 16'h3333);
    get(OP_READ, 22'h0a0020);
    chk(s[15:0], 16'h3333);
    $display("group test done");
  endtask
  task automatic t_edge();
    pins(3'b001);
    op(OP_PROGRAM, 22'h000020, 16'h4444);
    get(OP_READ, 22'h000020);
    chk(s[15:0], 16'hffff);
    pins(3'b011);
    op(OP_PROGRAM, 22'h000021, 16'h4444);
    get(OP_READ, 22'h000021);
    chk(s[15:0], 16'hffff);
    pins(3'b101);
    op(OP_PROGRAM, 22'h000022, 16'h4444);
    get(OP_READ, 22'h000022);
    chk(s[15:0], 16'h4444);
    $display("edge test done");
  endtask
  task automatic t_secure();
    op(OP_SECURE_ENTER, 22'h0, 16'h0);
    chk(s[3], 1'b1);
    op(OP_PROGRAM, 22'h000010, 16'h5a5a);
    get(OP_READ, 22'h000010);
    chk(s[15:0], 16'h5a5a);
    op(OP_WRITE, 22'h000042, 16'h0060);
    op(OP_PROGRAM, 22'h000011, 16'h6b6b);
    get(OP_READ, 22'h000011);
    chk(s[15:0], 16'hffff);
    op(OP_SECURE_EXIT, 22'h0, 16'h0);
    chk(s[3], 1'b0);
    get(OP_READ, 22'h000010);
    chk(s[15:0], 16'hffff);
    op(OP_SECURE_ENTER, 22'h0, 16'h0);
    pins(3'b100);
    pins(3'b101);
    rd(REG_STATUS);
    chk(s[3], 1'b0);
    op(OP_WRITE, UNLOCK_A1, UNLOCK_D1);
    op(OP_WRITE, UNLOCK_A2, UNLOCK_D2);
    op(OP_WRITE, UNLOCK_A1, CMD_AUTOSEL);
    get(OP_READ, 22'h000003);
    chk(s[15:0], 16'h0018);
    op(OP_RESET_CMD, 22'h0, 16'h0);
    $display("secure test done");
  endtask
  task automatic t_lock();
    lock <= 1'b1;
    repeat (8) @(posedge clk);
    op(OP_PROGRAM, 22'h000030, 16'h7777);
    chk({s[4], s[2]}, 2'b11);
    lock <= 1'b0;
    $display("lockout test done");
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails++;
    print_verdict();
  end
  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready, lock} = 7'b1000000;
    {awaddr, araddr, wdata, wstrb} = {8'h0, 8'h0, 32'h0, 4'hf};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_group();
    t_edge();
    t_secure();
    t_lock();
    print_verdict();
  end
endmodule
`default_nettype wire
